//--- include/rsc_defines.vh
// constants for the radiometer stepping and calibration sequencer
// assumes a 25 MHz mclk and the apb register map below
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// clock and times
`define RSC_CLK_HZ 25000000
`define RSC_BACKUP_PERIOD_MS 1260
`define RSC_BACKUP_CYCLES ((`RSC_CLK_HZ / 1000) * `RSC_BACKUP_PERIOD_MS)
`define RSC_SETTLE_MS 8
`define RSC_SETTLE_CYCLES ((`RSC_CLK_HZ / 1000) * `RSC_SETTLE_MS)
`define RSC_CNT_W 26

// register byte offsets
`define RSC_CTRL_ADDR 12'h000
`define RSC_CMD_ADDR 12'h004
`define RSC_STAT_ADDR 12'h008
`define RSC_CAL_ADDR 12'h00C

// command register bits (write one to issue)
`define RSC_CMD_DISABLE 0
`define RSC_CMD_STEP 1
`define RSC_CMD_RESUME 2

// control register fields
`define RSC_CTRL_BACKUP_EN 0
`define RSC_CTRL_RESET 32'h0000_0001

`endif

//--- rtl/rsc_pulse_detect.v
// rising edge detector with two-flop synchroniser for a pin input
// assumes the pin is asynchronous to mclk
`timescale 1ns/10ps
module rsc_pulse_detect (
  input wire mclk,
  input wire resetn,
  input wire pin_in,
  output reg pulse_out
);
  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;

  // synchronise, then flag the rising edge for one cycle
  always @(posedge mclk) begin
    if (!resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
      pulse_out <= sync2_reg & ~last_reg;
    end
  end
endmodule

//--- rtl/rsc_sequencer.v
// radiometer frequency stepping and calibration sequencer with apb
// assumes spacecraft pins are asynchronous and apb runs on mclk
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "rsc_defines.vh"
module rsc_sequencer (
  input wire mclk,
  input wire resetn,
  input wire timing_pin,
  input wire sync_pin,
  input wire cal_window_pin,
  input wire level_select_bit_a,
  input wire level_select_bit_b,
  input wire disable_stepping_cmd,
  input wire single_step_cmd,
  input wire resume_stepping_cmd,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  output reg [7:0] osc_power,
  output reg input_switch_driver,
  output reg frame_ident_word,
  output reg preamp_select_latch,
  output reg level_relay_a,
  output reg level_relay_b,
  output reg [1:0] cal_level_tlm,
  output reg osc_settled
);
  // detected pulses on the asynchronous pins
  wire step_tick;
  wire sync_pulse;
  wire dis_pulse;
  wire stp_pulse;
  wire res_pulse;

  rsc_pulse_detect u_tick (.mclk(mclk), .resetn(resetn),
    .pin_in(timing_pin), .pulse_out(step_tick));
  rsc_pulse_detect u_sync (.mclk(mclk), .resetn(resetn),
    .pin_in(sync_pin), .pulse_out(sync_pulse));
  rsc_pulse_detect u_dis (.mclk(mclk), .resetn(resetn),
    .pin_in(disable_stepping_cmd), .pulse_out(dis_pulse));
  rsc_pulse_detect u_stp (.mclk(mclk), .resetn(resetn),
    .pin_in(single_step_cmd), .pulse_out(stp_pulse));
  rsc_pulse_detect u_res (.mclk(mclk), .resetn(resetn),
    .pin_in(resume_stepping_cmd), .pulse_out(res_pulse));

  // level pins go through two flops
  reg [2:0] lvl_s1_reg;
  reg [2:0] lvl_s2_reg;
  always @(posedge mclk) begin
    if (!resetn) begin
      lvl_s1_reg <= 3'h0;
      lvl_s2_reg <= 3'h0;
    end else begin
      lvl_s1_reg <= {cal_window_pin, level_select_bit_b, level_select_bit_a};
      lvl_s2_reg <= lvl_s1_reg;
    end
  end
  wire cal_win = lvl_s2_reg[2];
  wire sel_a = lvl_s2_reg[0];
  wire sel_b = lvl_s2_reg[1];

  // apb registers: software commands and backup enable
  reg backup_en_reg;
  reg sw_dis_reg;
  reg sw_stp_reg;
  reg sw_res_reg;
  wire apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always @(posedge mclk) begin
    if (!resetn) begin
      backup_en_reg <= 1'b1;
      sw_dis_reg <= 1'b0;
      sw_stp_reg <= 1'b0;
      sw_res_reg <= 1'b0;
    end else begin
      sw_dis_reg <= 1'b0;
      sw_stp_reg <= 1'b0;
      sw_res_reg <= 1'b0;
      if (apb_wr && paddr == `RSC_CTRL_ADDR) begin
        backup_en_reg <= pwdata[`RSC_CTRL_BACKUP_EN];
      end
      if (apb_wr && paddr == `RSC_CMD_ADDR) begin
        sw_dis_reg <= pwdata[`RSC_CMD_DISABLE];
        sw_stp_reg <= pwdata[`RSC_CMD_STEP];
        sw_res_reg <= pwdata[`RSC_CMD_RESUME];
      end
    end
  end

  // stepping disable latch; disable wins if both arrive together
  reg fixed_reg;
  always @(posedge mclk) begin
    if (!resetn) begin
      fixed_reg <= 1'b0;
    end else if (dis_pulse | sw_dis_reg) begin
      fixed_reg <= 1'b1;
    end else if (res_pulse | sw_res_reg) begin
      fixed_reg <= 1'b0;
    end
  end

  // backup pulse unit: free runs, restarted by each detected tick
  reg [`RSC_CNT_W-1:0] backup_cnt_reg;
  reg backup_pulse_reg;
  // terminal count worked out at full width, then cut to counter width
  localparam integer BACKUP_LAST_I = `RSC_BACKUP_CYCLES - 1;
  localparam [`RSC_CNT_W-1:0] BACKUP_LAST = BACKUP_LAST_I[`RSC_CNT_W-1:0];
  always @(posedge mclk) begin
    if (!resetn) begin
      backup_cnt_reg <= {`RSC_CNT_W{1'b0}};
      backup_pulse_reg <= 1'b0;
    end else if (step_tick) begin
      backup_cnt_reg <= {`RSC_CNT_W{1'b0}};
      backup_pulse_reg <= 1'b0;
    end else if (backup_cnt_reg == BACKUP_LAST) begin
      backup_cnt_reg <= {`RSC_CNT_W{1'b0}};
      backup_pulse_reg <= backup_en_reg;
    end else begin
      backup_cnt_reg <= backup_cnt_reg + 1'b1;
      backup_pulse_reg <= 1'b0;
    end
  end

  // stepping source: or of tick and backup, or single step in fixed mode
  wire auto_step = (step_tick | backup_pulse_reg) & ~fixed_reg;
  wire man_step = (stp_pulse | sw_stp_reg) & fixed_reg;
  wire sync_rst = sync_pulse & ~fixed_reg;

  // eight-stage frequency counter
  reg [2:0] freq_reg;
  always @(posedge mclk) begin
    if (!resetn) begin
      freq_reg <= 3'h0;
    end else if (sync_rst) begin
      freq_reg <= 3'h0;
    end else if (auto_step | man_step) begin
      freq_reg <= freq_reg + 3'h1;
    end
  end

  // one-hot oscillator power switches
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_osc
      always @(posedge mclk) begin
        if (!resetn) begin
          osc_power[gi] <= (gi == 0);
        end else begin
          osc_power[gi] <= (freq_reg == gi);
        end
      end
    end
  endgenerate

  // settle timer after each oscillator change
  reg [17:0] settle_cnt_reg;
  reg [2:0] freq_last_reg;
  localparam integer SETTLE_LAST_I = `RSC_SETTLE_CYCLES;
  localparam [17:0] SETTLE_LAST = SETTLE_LAST_I[17:0];
  always @(posedge mclk) begin
    if (!resetn) begin
      settle_cnt_reg <= 18'h0;
      freq_last_reg <= 3'h0;
      osc_settled <= 1'b0;
    end else begin
      freq_last_reg <= freq_reg;
      if (freq_reg != freq_last_reg) begin
        settle_cnt_reg <= 18'h0;
        osc_settled <= 1'b0;
      end else if (settle_cnt_reg != SETTLE_LAST) begin
        settle_cnt_reg <= settle_cnt_reg + 18'h1;
        osc_settled <= 1'b0;
      end else begin
        osc_settled <= 1'b1;
      end
    end
  end

  // calibration control
  wire gate_a = cal_win & sel_a;
  wire gate_b = cal_win & sel_b;
  reg cal_win_last_reg;
  always @(posedge mclk) begin
    if (!resetn) begin
      cal_win_last_reg <= 1'b0;
      preamp_select_latch <= 1'b0;
      input_switch_driver <= 1'b0;
      frame_ident_word <= 1'b0;
      level_relay_a <= 1'b0;
      level_relay_b <= 1'b0;
      cal_level_tlm <= 2'h0;
    end else begin
      cal_win_last_reg <= cal_win;
      if (cal_win & ~cal_win_last_reg) begin
        preamp_select_latch <= ~preamp_select_latch;
      end
      input_switch_driver <= cal_win;
      frame_ident_word <= cal_win;
      level_relay_a <= gate_a;
      level_relay_b <= gate_b;
      // telemetry level: 3 max, 2 second, 1 third and no-noise, 0 idle
      case ({cal_win, gate_a, gate_b})
        3'b111: cal_level_tlm <= 2'h3;
        3'b101: cal_level_tlm <= 2'h2;
        3'b110: cal_level_tlm <= 2'h1;
        3'b100: cal_level_tlm <= 2'h1;
        default: cal_level_tlm <= 2'h0;
      endcase
    end
  end

  // apb read mux, registered data not needed: zero wait states
  always @* begin
    case (paddr)
      `RSC_CTRL_ADDR: prdata = {31'h0, backup_en_reg};
      `RSC_STAT_ADDR: prdata = {23'h0, osc_settled, fixed_reg, 4'h0,
        freq_reg};
      `RSC_CAL_ADDR: prdata = {24'h0, cal_level_tlm, level_relay_b,
        level_relay_a, preamp_select_latch, frame_ident_word,
        input_switch_driver, cal_win};
      default: prdata = 32'h0;
    endcase
  end
endmodule

//--- test/rsc_sc_model.sv
// spacecraft timing and calibration side model
// assumes bench mclk; pins change just after rising edges
`timescale 1ns/10ps
module rsc_sc_model (
  input wire mclk,
  output logic timing_pin,
  output logic sync_pin,
  output logic cal_window_pin,
  output logic level_select_bit_a,
  output logic level_select_bit_b
);
  // all lines idle low
  initial begin
    {timing_pin, sync_pin, cal_window_pin} = 3'h0;
    {level_select_bit_a, level_select_bit_b} = 2'h0;
  end
  // step (s=0) or sync (s=1) pulses, four high then four low
  task pulse(input bit s, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (s) sync_pin <= 1'b1;
      else timing_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      {sync_pin, timing_pin} <= 2'h0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // one calibration subcycle: window and level bits held
  task level(input bit w, input bit a, input bit b);
    @(posedge mclk);
    cal_window_pin <= w;
    {level_select_bit_a, level_select_bit_b} <= {a, b};
    repeat (12) @(posedge mclk);
  endtask
endmodule

//--- test/rsc_seq_properties.sv
// concurrent checks on the sequencer outputs
// assumes one mclk domain with synchronous active-low resetn
`timescale 1ns/10ps
module rsc_seq_props (
  input wire mclk,
  input wire resetn,
  input wire [7:0] osc_power,
  input wire input_switch_driver,
  input wire frame_ident_word,
  input wire preamp_select_latch,
  input wire level_relay_a,
  input wire level_relay_b,
  input wire [1:0] cal_level_tlm,
  input wire osc_settled
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // oscillator power, relays and telemetry relations
  a_one_osc_on: assert property ($onehot(osc_power))
    else $error("oscillator power not one-hot");
  a_reset_state: assert property (
    $rose(resetn) |-> osc_power == 8'h01)
    else $error("lowest oscillator not on after reset");
  a_switch_frame: assert property (
    input_switch_driver == frame_ident_word)
    else $error("input switch and frame level differ");
  a_relay_window: assert property (
    level_relay_a | level_relay_b |-> input_switch_driver)
    else $error("level relay on outside window");
  a_tlm_max: assert property (
    (cal_level_tlm == 2'h3) == (level_relay_a & level_relay_b))
    else $error("max level indication wrong");
  a_tlm_second: assert property (
    (cal_level_tlm == 2'h2) == (!level_relay_a & level_relay_b))
    else $error("second level indication wrong");
  a_tlm_low: assert property (
    (cal_level_tlm == 2'h1) == (input_switch_driver & !level_relay_b))
    else $error("low level indication wrong");
  // the latch flips in the very cycle the window output rises, no other
  a_preamp_toggle: assert property (
    $changed(preamp_select_latch) == $rose(input_switch_driver))
    else $error("preamp select not toggled at window start");
  a_settle_drop: assert property (
    $changed(osc_power) |=> !osc_settled)
    else $error("settled flag high right after a step");
  cover property (cal_level_tlm == 2'h3);
  cover property ($changed(preamp_select_latch));
  cover property (osc_power[7] ##1 osc_power[0]);
endmodule

bind rsc_sequencer rsc_seq_props chk_u (.*);

//--- test/tb_radiometer_step_cal_sequencer.sv
// self-checking bench for the stepping and calibration sequencer
// assumes the spacecraft model drives the timing and calibration pins
`timescale 1ns/10ps
`include "rsc_defines.vh"
module tb_radiometer_step_cal_sequencer;
  logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] cv = 3'h0;
  wire disable_stepping_cmd = cv[0];
  wire single_step_cmd = cv[1];
  wire resume_stepping_cmd = cv[2];
  wire pready, pslverr, input_switch_driver, frame_ident_word, osc_settled;
  wire preamp_select_latch, level_relay_a, level_relay_b;
  wire timing_pin, sync_pin, cal_window_pin;
  wire level_select_bit_a, level_select_bit_b;
  wire [7:0] osc_power;
  wire [1:0] cal_level_tlm;
  int miscompares = 0, check_count = 0, f = 0, seed = 32'h3652;
  bit fx = 1'b0, pl = 1'b0;
  bit [1:0] lv[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  rsc_sequencer dut_u (.*);
  rsc_sc_model sc_u (.*);
  always #20 mclk = ~mclk;
  // result comparison
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input bit w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk) penable <= 1'b1;
    // no cycle limit here: a hung transfer is ended by the watchdog
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    chk("pslverr", 32'h0, pslverr);
    {psel, penable} <= 2'h0;
  endtask
  // command pin pulse: 0 disable, 1 single step, 2 resume
  task cmd(input int k);
    @(posedge mclk) cv <= 3'h1 << k;
    repeat (4) @(posedge mclk);
    cv <= 3'h0;
  endtask
  // frequency state against the model
  task st;
    logic [31:0] q;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk("osc_power", 8'h01 << f, osc_power);
    apb(0, `RSC_STAT_ADDR, 0, q);
    chk("stat", {fx, 4'h0, f[2:0]}, q);
  endtask
  // calibration outputs against the model
  task cal(input bit w, input bit [1:0] ab);
    logic [1:0] e;
    e = !w ? 2'h0 : ab == 2'h3 ? 2'h3 : ab == 2'h1 ? 2'h2 : 2'h1;
    @(negedge mclk);
    chk("relays", {w & ab[1], w & ab[0]},
      {level_relay_a, level_relay_b});
    chk("window", {w, w, pl},
      {input_switch_driver, frame_ident_word, preamp_select_latch});
    chk("tlm", e, cal_level_tlm);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] q;
    int n;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    apb(0, `RSC_CTRL_ADDR, 0, q);
    chk("ctrl", 32'h1, q);
    apb(1, `RSC_CTRL_ADDR, 32'h0, q);
    apb(0, `RSC_CTRL_ADDR, 0, q);
    chk("ctrl", 32'h0, q);
    apb(1, `RSC_CTRL_ADDR, 32'h1, q);
    apb(0, 12'h010, 0, q);
    chk("unmapped", 32'h0, q);
    st;
    repeat (4) begin
      n = ($random(seed) & 7) + 1;
      sc_u.pulse(0, n);
      f = (f + n) % 8;
      st;
    end
    repeat (2) begin
      sc_u.pulse(1, 1);
      f = 0;
      st;
    end
    apb(1, `RSC_CMD_ADDR, 32'h1, q);
    fx = 1'b1;
    sc_u.pulse(0, 3);
    cmd(1);
    f = (f + 1) % 8;
    sc_u.pulse(1, 1);
    st;
    apb(1, `RSC_CMD_ADDR, 32'h2, q);
    f = (f + 1) % 8;
    st;
    cmd(2);
    fx = 1'b0;
    sc_u.pulse(0, 1);
    f = (f + 1) % 8;
    st;
    cmd(0);
    fx = 1'b1;
    st;
    apb(1, `RSC_CMD_ADDR, 32'h4, q);
    fx = 1'b0;
    st;
    repeat (2) begin
      pl = !pl;
      foreach (lv[i]) begin
        sc_u.level(1, lv[i][1], lv[i][0]);
        cal(1, lv[i]);
      end
      sc_u.level(0, 1, 1);
      cal(0, 2'h3);
    end
    close_out;
  end
  // watchdog
  initial begin
    #800000;
    miscompares++;
    close_out;
  end
endmodule
